// file: inc/bpms_defs.svh
// Constants for the backup power mode sequencer
`ifndef BPMS_DEFS_SVH
`define BPMS_DEFS_SVH

// Switch position codes
`define BPMS_SW_1MIN 4'h0
`define BPMS_SW_2MIN 4'h1
`define BPMS_SW_3MIN 4'h2
`define BPMS_SW_5MIN 4'h3
`define BPMS_SW_10MIN 4'h4
`define BPMS_SW_15MIN 4'h5
`define BPMS_SW_CUSTOM 4'h6
`define BPMS_SW_UNLIM 4'h7
`define BPMS_SW_PC 4'h8
`define BPMS_SW_SERVICE 4'h9

// Preset buffer times in minutes
`define BPMS_MIN_1 16'h0001
`define BPMS_MIN_2 16'h0002
`define BPMS_MIN_3 16'h0003
`define BPMS_MIN_5 16'h0005
`define BPMS_MIN_10 16'h000a
`define BPMS_MIN_15 16'h000f
`define BPMS_SEC_PER_MIN 16'h003c

// Custom default buffer time, seconds
`define BPMS_CUSTOM_DEFAULT_S 16'h001e

// One-second tick: 1 s at 100 MHz
`define BPMS_TICK_NS 1000000000
`define BPMS_CLK_NS 10
`define BPMS_TICK_CYCLES (`BPMS_TICK_NS / `BPMS_CLK_NS)

// Alarm threshold, storage voltage in units of 0.1 V (20.4 V)
`define BPMS_ALARM_DV 12'h0cc

// Green flash half period in ticks
`define BPMS_FLASH_TICKS 16'h0001

`endif

// file: inc/bpms_pkg.sv
// Types for the backup power mode sequencer
package bpms_pkg;

  typedef enum logic [2:0] {
    BPMS_MAINS,
    BPMS_BATT,
    BPMS_PC_DELAY,
    BPMS_PC_PROG,
    BPMS_PC_SHUT,
    BPMS_PC_IDLE,
    BPMS_OFF
  } bpms_state_type;

  // Software-set configuration; times in seconds, alarm threshold in units of 0.1 V
  typedef struct packed {
    logic custom_valid;
    logic [15:0] custom_s;
    logic [15:0] delay_s;
    logic [15:0] prog_s;
    logic [15:0] shut_s;
    logic [15:0] idle_s;
    logic remote_invert;
    logic [11:0] alarm_dv;
  } bpms_cfg_type;

  typedef struct packed {
    logic out_on;
    logic batt_path_on;
    logic in_battery;
    logic alarm;
    logic active_sig;
    logic green_flash;
    logic prog_start;
    logic remote_flag;
  } bpms_stat_type;

endpackage : bpms_pkg

// file: hw/bpms_sync.sv
// Two-flop synchroniser for pin inputs
module bpms_sync #(
  // Reset to the pin's idle level, else a false event follows reset
  parameter logic RST_VAL = 1'b0
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic din,
  output logic dout
);
  logic meta_ff;
  logic sync_ff;
  logic nxt_meta;
  logic nxt_sync;

  always_comb begin
    nxt_meta = ce ? din : meta_ff;
    nxt_sync = ce ? meta_ff : sync_ff;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign dout = sync_ff;
endmodule : bpms_sync

// file: hw/bpms_tick.sv
// One-second tick prescaler
`include "bpms_defs.svh"
module bpms_tick (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  output logic tick
);
  localparam int TICK_CYCLES = `BPMS_TICK_CYCLES;
  logic [26:0] cnt_ff;
  logic [26:0] nxt_cnt;
  logic tick_ff;
  logic nxt_tick;

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_tick = 1'b0;
    if (ce) begin
      if (cnt_ff == 27'(TICK_CYCLES - 1)) begin
        nxt_cnt = '0;
        nxt_tick = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 27'h1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;
endmodule : bpms_tick

// file: hw/bpms_sequencer.sv
// Mode sequencer: buffer timing, PC shutdown sequence, service and remote handling
// Notes on behaviour
// - Operating function follows the front switch position.
// - Fixed positions switch output off after set minutes of battery time.
// - Custom position uses software time, else 30 seconds.
// - Unlimited position buffers on; alarm when storage below 20.4 V default.
// - PC mode runs delay timer after mains failure, then heads to shutdown.
// - PC mode may trigger program start after delay expires.
// - After delay and program time, shutdown interval runs, then output off.
// - Mains back during shutdown: finish, output off for idle, then restart.
// - Remote present at mains failure in PC mode skips the delay.
// - Service mode entered only while input voltage present.
// - Input fails in service: unlimited battery operation, normal signalling.
// - Service mode disables battery path except in that failure case.
// - Entering service mode always asserts the active signal output.
// - Remote input tied to signal ground sets the internal remote flag.
// - Battery suppression remote function active for preset times, custom position and PC mode.
// - Remote in mains flashes green; next mains failure turns output off, except in PC mode where it skips the delay.
// - Remote during battery operation ends it and switches output off; in PC mode only during the delay.
// - Remote shutdown holds output off until input voltage returns.
// - Software may invert remote input polarity before the flag.
`include "bpms_defs.svh"
module bpms_sequencer (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic mains_ok_pin,
  input wire logic remote_n_pin,
  input wire logic [3:0] switch_pos,
  input wire logic [11:0] storage_dv,
  input wire bpms_pkg::bpms_cfg_type cfg,
  output bpms_pkg::bpms_stat_type stat
);

  // ==========================================================
  // Input synchronisers and tick
  // ==========================================================
  logic mains_ok;
  logic remote_n;
  logic tick;

  // Mains assumed present and remote idle, so reset release causes no transition
  bpms_sync #(.RST_VAL(1'b1)) u_sync_mains (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .din(mains_ok_pin),
    .dout(mains_ok)
  );

  bpms_sync #(.RST_VAL(1'b1)) u_sync_remote (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .din(remote_n_pin),
    .dout(remote_n)
  );

  bpms_tick u_tick (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .tick(tick)
  );

  // Pin is low when tied to signal ground
  logic remote_act;
  assign remote_act = (~remote_n) ^ cfg.remote_invert;

  // ==========================================================
  // Helpers
  // ==========================================================
  // Buffer time in seconds for a timed position
  function automatic logic [15:0] buf_secs(input logic [3:0] pos, input bpms_pkg::bpms_cfg_type c);
    logic [31:0] m;
    m = 32'h0;
    case (pos)
      `BPMS_SW_1MIN: m = 32'(`BPMS_MIN_1) * 32'(`BPMS_SEC_PER_MIN);
      `BPMS_SW_2MIN: m = 32'(`BPMS_MIN_2) * 32'(`BPMS_SEC_PER_MIN);
      `BPMS_SW_3MIN: m = 32'(`BPMS_MIN_3) * 32'(`BPMS_SEC_PER_MIN);
      `BPMS_SW_5MIN: m = 32'(`BPMS_MIN_5) * 32'(`BPMS_SEC_PER_MIN);
      `BPMS_SW_10MIN: m = 32'(`BPMS_MIN_10) * 32'(`BPMS_SEC_PER_MIN);
      `BPMS_SW_15MIN: m = 32'(`BPMS_MIN_15) * 32'(`BPMS_SEC_PER_MIN);
      `BPMS_SW_CUSTOM: m = c.custom_valid ? 32'(c.custom_s) : 32'(`BPMS_CUSTOM_DEFAULT_S);
      default: m = 32'h0;
    endcase
    return m[15:0];
  endfunction : buf_secs

  function automatic logic is_timed(input logic [3:0] pos);
    return pos <= `BPMS_SW_CUSTOM;
  endfunction : is_timed

  // ==========================================================
  // State
  // ==========================================================
  bpms_pkg::bpms_state_type state_ff;
  bpms_pkg::bpms_state_type nxt_state;
  logic [15:0] secs_ff;
  logic [15:0] nxt_secs;
  logic [15:0] limit_ff;
  logic [15:0] nxt_limit;
  logic service_ff;
  logic nxt_service;
  logic unlim_ff;
  logic nxt_unlim;
  logic restart_ff;
  logic nxt_restart;
  logic flash_ff;
  logic nxt_flash;
  logic flash_arm_ff;
  logic nxt_flash_arm;
  logic prog_ff;
  logic nxt_prog;
  logic active_ff;
  logic nxt_active;
  logic alarm_ff;
  logic nxt_alarm;

  logic timer_done;
  logic suppress_fn;
  logic pc_mode;
  assign timer_done = (secs_ff >= limit_ff);
  assign pc_mode = (switch_pos == `BPMS_SW_PC);
  assign suppress_fn = is_timed(switch_pos) || pc_mode;

  always_comb begin
    nxt_state = state_ff;
    nxt_secs = secs_ff;
    nxt_limit = limit_ff;
    nxt_service = service_ff;
    nxt_unlim = unlim_ff;
    nxt_restart = restart_ff;
    nxt_flash = flash_ff;
    nxt_flash_arm = flash_arm_ff;
    nxt_prog = 1'b0;
    nxt_active = active_ff;
    nxt_alarm = alarm_ff;
    if (ce) begin
      if (tick && (secs_ff != 16'hffff)) begin
        nxt_secs = secs_ff + 16'h1;
      end
      case (state_ff)
        bpms_pkg::BPMS_MAINS: begin
          nxt_alarm = 1'b0;
          nxt_restart = 1'b0;
          // Service only with input present; leaving it drops the forced active output
          if (switch_pos == `BPMS_SW_SERVICE) begin
            if (mains_ok && !service_ff) begin
              nxt_service = 1'b1;
              nxt_active = 1'b1;
            end
          end else begin
            nxt_service = 1'b0;
            nxt_active = 1'b0;
          end
          // Light at once on the first cycle, then blink per tick
          if (remote_act && suppress_fn) begin
            nxt_flash_arm = 1'b1;
            if (tick || !flash_arm_ff) begin
              nxt_flash = ~flash_ff;
            end
          end else begin
            nxt_flash = 1'b0;
            nxt_flash_arm = 1'b0;
          end
          if (!mains_ok) begin
            nxt_secs = 16'h0;
            nxt_flash = 1'b0;
            nxt_flash_arm = 1'b0;
            if (service_ff || switch_pos == `BPMS_SW_UNLIM) begin
              nxt_state = bpms_pkg::BPMS_BATT;
              nxt_unlim = 1'b1;
              // Normal battery signalling; service is re-entered once input returns
              nxt_service = 1'b0;
              nxt_active = 1'b0;
            end else if (pc_mode) begin
              if (remote_act) begin
                nxt_state = bpms_pkg::BPMS_PC_PROG;
                nxt_limit = cfg.prog_s;
                nxt_prog = 1'b1;
              end else begin
                nxt_state = bpms_pkg::BPMS_PC_DELAY;
                nxt_limit = cfg.delay_s;
              end
            end else if (remote_act && suppress_fn) begin
              nxt_state = bpms_pkg::BPMS_OFF;
            end else if (is_timed(switch_pos)) begin
              nxt_state = bpms_pkg::BPMS_BATT;
              nxt_unlim = 1'b0;
              nxt_limit = buf_secs(switch_pos, cfg);
            end
            // Service position without a prior valid entry is ignored
          end
        end
        bpms_pkg::BPMS_BATT: begin
          nxt_alarm = unlim_ff && (storage_dv < cfg.alarm_dv);
          if (mains_ok) begin
            nxt_state = bpms_pkg::BPMS_MAINS;
          end else if (remote_act && suppress_fn && !service_ff) begin
            nxt_state = bpms_pkg::BPMS_OFF;
          end else if (!unlim_ff && timer_done) begin
            nxt_state = bpms_pkg::BPMS_OFF;
          end
        end
        bpms_pkg::BPMS_PC_DELAY: begin
          if (mains_ok) begin
            nxt_state = bpms_pkg::BPMS_MAINS;
          end else if (remote_act) begin
            nxt_state = bpms_pkg::BPMS_OFF;
          end else if (timer_done) begin
            nxt_state = bpms_pkg::BPMS_PC_PROG;
            nxt_secs = 16'h0;
            nxt_limit = cfg.prog_s;
            nxt_prog = 1'b1;
          end
        end
        bpms_pkg::BPMS_PC_PROG: begin
          if (timer_done) begin
            nxt_state = bpms_pkg::BPMS_PC_SHUT;
            nxt_secs = 16'h0;
            nxt_limit = cfg.shut_s;
          end
          if (mains_ok) begin
            nxt_restart = 1'b1;
          end
        end
        bpms_pkg::BPMS_PC_SHUT: begin
          // Shutdown cannot be aborted once the PC has been told to go down
          if (mains_ok) begin
            nxt_restart = 1'b1;
          end
          if (timer_done) begin
            nxt_secs = 16'h0;
            if (restart_ff || mains_ok) begin
              nxt_state = bpms_pkg::BPMS_PC_IDLE;
              nxt_limit = cfg.idle_s;
            end else begin
              nxt_state = bpms_pkg::BPMS_OFF;
            end
          end
        end
        bpms_pkg::BPMS_PC_IDLE: begin
          if (timer_done) begin
            nxt_state = bpms_pkg::BPMS_MAINS;
          end
        end
        bpms_pkg::BPMS_OFF: begin
          if (mains_ok) begin
            nxt_state = bpms_pkg::BPMS_MAINS;
          end
        end
        default: begin
          nxt_state = bpms_pkg::BPMS_MAINS;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff <= bpms_pkg::BPMS_MAINS;
      secs_ff <= 16'h0;
      limit_ff <= 16'h0;
      service_ff <= 1'b0;
      unlim_ff <= 1'b0;
      restart_ff <= 1'b0;
      flash_ff <= 1'b0;
      flash_arm_ff <= 1'b0;
      prog_ff <= 1'b0;
      active_ff <= 1'b0;
      alarm_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      secs_ff <= nxt_secs;
      limit_ff <= nxt_limit;
      service_ff <= nxt_service;
      unlim_ff <= nxt_unlim;
      restart_ff <= nxt_restart;
      flash_ff <= nxt_flash;
      flash_arm_ff <= nxt_flash_arm;
      prog_ff <= nxt_prog;
      active_ff <= nxt_active;
      alarm_ff <= nxt_alarm;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  logic in_batt;
  assign in_batt = (state_ff == bpms_pkg::BPMS_BATT) || (state_ff == bpms_pkg::BPMS_PC_DELAY) ||
                   (state_ff == bpms_pkg::BPMS_PC_PROG) ||
                   ((state_ff == bpms_pkg::BPMS_PC_SHUT) && !mains_ok);

  always_comb begin
    stat.out_on = (state_ff != bpms_pkg::BPMS_OFF) && (state_ff != bpms_pkg::BPMS_PC_IDLE);
    stat.batt_path_on = !(service_ff && state_ff == bpms_pkg::BPMS_MAINS);
    stat.in_battery = in_batt;
    stat.alarm = alarm_ff;
    stat.active_sig = active_ff && state_ff == bpms_pkg::BPMS_MAINS;
    stat.green_flash = flash_ff;
    stat.prog_start = prog_ff;
    stat.remote_flag = remote_act;
  end

endmodule : bpms_sequencer

// file: verif/bpms_sequencer_checker.sv
// Port checker for the backup power mode sequencer
`include "bpms_defs.svh"
module bpms_sequencer_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic mains_ok_pin,
  input wire logic remote_n_pin,
  input wire logic [3:0] switch_pos,
  input wire logic [11:0] storage_dv,
  input wire bpms_pkg::bpms_cfg_type cfg,
  input wire bpms_pkg::bpms_stat_type stat
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dcb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // ===========================================
  // Sequences
  sequence s_fail_start;
    $fell(mains_ok_pin) && stat.out_on && !stat.remote_flag && ce &&
      (switch_pos <= `BPMS_SW_15MIN || switch_pos == `BPMS_SW_SERVICE);
  endsequence
  sequence s_fail_hold;
    s_fail_start ##1 (!mains_ok_pin && !stat.remote_flag && ce)[*3];
  endsequence
  // ===========================================
  // Assertions
  a_fail_to_battery: assert property (s_fail_hold |-> stat.in_battery)
    else $error("Mains failure did not start battery operation");
  a_remote_map: assert property (
    ce && $past(ce) && $past(ce, 2) && !$past(rst) && !$past(rst, 2) |->
      stat.remote_flag == (!$past(remote_n_pin, 2) ^ cfg.remote_invert))
    else $error("Remote flag does not follow pin and polarity");
  a_remote_cuts_batt: assert property (
    stat.in_battery && stat.remote_flag && switch_pos <= `BPMS_SW_15MIN && ce |-> ##[0:2] !stat.out_on)
    else $error("Remote in battery did not switch output off");
  a_off_holds: assert property (
    !stat.out_on && !mains_ok_pin && !$past(mains_ok_pin) && !$past(mains_ok_pin, 2) &&
      switch_pos != `BPMS_SW_PC |=> !stat.out_on)
    else $error("Output came back without input voltage");
  a_service_path: assert property (stat.active_sig |-> !stat.batt_path_on && stat.out_on)
    else $error("Battery path enabled in service mode");
  a_active_cause: assert property (
    $rose(stat.active_sig) |-> switch_pos == `BPMS_SW_SERVICE || $past(switch_pos) == `BPMS_SW_SERVICE)
    else $error("Active signal rose outside service position");
  a_prog_pulse: assert property ($rose(stat.prog_start) && ce |=> !stat.prog_start)
    else $error("Program start pulse longer than one cycle");
  a_unlim_alarm: assert property (
    (stat.in_battery && switch_pos == `BPMS_SW_UNLIM && storage_dv < cfg.alarm_dv && ce)[*2] |->
      ##[0:2] stat.alarm)
    else $error("Low storage voltage raised no alarm");
endmodule : bpms_sequencer_checker

// file: verif/bpms_pc_model.sv
// Industrial PC side: remote contact and supply watch
module bpms_pc_model (
  input wire logic out_on,
  input wire logic contact_closed,
  output logic remote_n_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int power_ups = 0;
  // Closed contact ties to signal ground, pull-up otherwise
  assign remote_n_pin = contact_closed ? 1'b0 : 1'b1;
  always @(posedge out_on) begin
    power_ups++;
  end
endmodule : bpms_pc_model

// file: verif/tb_backup_power_mode_sequencer.sv
// Testbench for the backup power mode sequencer
`include "bpms_defs.svh"
module tb_backup_power_mode_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic mains_ok_pin = 1'b1;
  logic contact_closed = 1'b0;
  logic remote_n_pin;
  logic [3:0] switch_pos = `BPMS_SW_1MIN;
  logic [11:0] storage_dv = 12'h100;
  bpms_pkg::bpms_cfg_type cfg;
  bpms_pkg::bpms_stat_type stat;
  int n_errors = 0;
  int checks_done = 0;
  always #5 mclk = ~mclk;
  bpms_sequencer DUT (.mclk(mclk), .rst(rst), .ce(ce), .mains_ok_pin(mains_ok_pin), .remote_n_pin(remote_n_pin),
    .switch_pos(switch_pos), .storage_dv(storage_dv), .cfg(cfg), .stat(stat));
  bpms_pc_model u_pc (.out_on(stat.out_on), .contact_closed(contact_closed), .remote_n_pin(remote_n_pin));
  // ===========================================
  // Helpers
  task automatic chk(input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk
  // Inputs always move 1 ns after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  // ===========================================
  // Scenarios
  task automatic t_timed();
    for (int i = 0; i < 7; i++) begin
      switch_pos = i[3:0];
      mains_ok_pin = 1'b0;
      cyc(5);
      chk(1'b1, stat.in_battery);
      chk(1'b1, stat.out_on);
      mains_ok_pin = 1'b1;
      cyc(5);
      chk(1'b0, stat.in_battery);
      chk(1'b1, stat.out_on);
    end
  endtask : t_timed
  task automatic t_remote_batt();
    switch_pos = `BPMS_SW_5MIN;
    mains_ok_pin = 1'b0;
    cyc(5);
    contact_closed = 1'b1;
    cyc(5);
    chk(1'b0, stat.out_on);
    contact_closed = 1'b0;
    cyc(5);
    chk(1'b0, stat.out_on);
    mains_ok_pin = 1'b1;
    cyc(5);
    chk(1'b1, stat.out_on);
  endtask : t_remote_batt
  task automatic t_remote_mains();
    switch_pos = `BPMS_SW_10MIN;
    contact_closed = 1'b1;
    cyc(5);
    chk(1'b1, stat.remote_flag);
    chk(1'b1, stat.out_on);
    chk(1'b1, stat.green_flash);
    mains_ok_pin = 1'b0;
    cyc(5);
    chk(1'b0, stat.out_on);
    chk(1'b0, stat.green_flash);
    mains_ok_pin = 1'b1;
    contact_closed = 1'b0;
    cyc(5);
    chk(1'b1, stat.out_on);
  endtask : t_remote_mains
  task automatic t_invert();
    cfg.remote_invert = 1'b1;
    cyc(4);
    chk(1'b1, stat.remote_flag);
    contact_closed = 1'b1;
    cyc(4);
    chk(1'b0, stat.remote_flag);
    contact_closed = 1'b0;
    cfg.remote_invert = 1'b0;
    cyc(4);
    chk(1'b0, stat.remote_flag);
  endtask : t_invert
  task automatic t_service();
    switch_pos = `BPMS_SW_SERVICE;
    cyc(4);
    chk(1'b1, stat.active_sig);
    chk(1'b0, stat.batt_path_on);
    mains_ok_pin = 1'b0;
    cyc(5);
    chk(1'b1, stat.in_battery);
    chk(1'b1, stat.out_on);
    chk(1'b1, stat.batt_path_on);
    mains_ok_pin = 1'b1;
    switch_pos = `BPMS_SW_UNLIM;
    cyc(5);
    mains_ok_pin = 1'b0;
    cyc(5);
    switch_pos = `BPMS_SW_SERVICE;
    cyc(4);
    chk(1'b0, stat.active_sig);
    chk(1'b1, stat.in_battery);
    mains_ok_pin = 1'b1;
    switch_pos = `BPMS_SW_UNLIM;
    cyc(5);
  endtask : t_service
  task automatic t_alarm();
    switch_pos = `BPMS_SW_UNLIM;
    storage_dv = 12'h0cc;
    mains_ok_pin = 1'b0;
    cyc(5);
    chk(1'b0, stat.alarm);
    storage_dv = 12'h0cb;
    cyc(4);
    chk(1'b1, stat.alarm);
    chk(1'b1, stat.out_on);
    mains_ok_pin = 1'b1;
    storage_dv = 12'h100;
    cyc(5);
  endtask : t_alarm
  task automatic t_freeze();
    switch_pos = `BPMS_SW_1MIN;
    ce = 1'b0;
    mains_ok_pin = 1'b0;
    cyc(5);
    chk(1'b0, stat.in_battery);
    ce = 1'b1;
    cyc(5);
    chk(1'b1, stat.in_battery);
    mains_ok_pin = 1'b1;
    cyc(5);
  endtask : t_freeze
  // Zero software time expires at once
  task automatic t_custom();
    cfg.custom_valid = 1'b1;
    switch_pos = `BPMS_SW_CUSTOM;
    mains_ok_pin = 1'b0;
    cyc(6);
    chk(1'b0, stat.out_on);
    chk(1'b0, stat.in_battery);
    mains_ok_pin = 1'b1;
    cyc(5);
    chk(1'b1, stat.out_on);
    cfg.custom_valid = 1'b0;
  endtask : t_custom
  task automatic t_pc_seq();
    int ups;
    switch_pos = `BPMS_SW_PC;
    mains_ok_pin = 1'b0;
    cyc(5);
    chk(1'b1, stat.in_battery);
    chk(1'b1, stat.out_on);
    mains_ok_pin = 1'b1;
    cyc(5);
    chk(1'b0, stat.in_battery);
    cfg.delay_s = 16'h0000;
    cfg.prog_s = 16'h0000;
    cfg.shut_s = 16'h0000;
    cfg.idle_s = 16'h0000;
    mains_ok_pin = 1'b0;
    cyc(8);
    chk(1'b0, stat.out_on);
    mains_ok_pin = 1'b1;
    cyc(5);
    chk(1'b1, stat.out_on);
    // Dip of two samples: mains is back while the PC goes down
    ups = u_pc.power_ups;
    mains_ok_pin = 1'b0;
    cyc(2);
    mains_ok_pin = 1'b1;
    cyc(10);
    chk(1'b1, stat.out_on);
    chk(1'b1, u_pc.power_ups == ups + 1);
    cfg.delay_s = 16'h000a;
    cfg.prog_s = 16'h000a;
    cfg.shut_s = 16'h000a;
    cfg.idle_s = 16'h000a;
  endtask : t_pc_seq
  // Last: the PC program and shutdown sequence it starts needs whole seconds to finish
  task automatic t_pc();
    logic seen;
    seen = 1'b0;
    switch_pos = `BPMS_SW_PC;
    contact_closed = 1'b1;
    cyc(4);
    mains_ok_pin = 1'b0;
    for (int i = 0; i < 20 && !seen; i++) begin
      cyc(1);
      seen = (stat.prog_start === 1'b1);
    end
    chk(1'b1, seen);
    chk(1'b1, stat.out_on);
    if (!seen) begin
      complete_run();
    end
  endtask : t_pc
  // ===========================================
  // Main sequence
  initial begin
    cfg = '{custom_valid: 1'b0, custom_s: 16'h0000, delay_s: 16'h000a, prog_s: 16'h000a, shut_s: 16'h000a,
      idle_s: 16'h000a, remote_invert: 1'b0, alarm_dv: `BPMS_ALARM_DV};
    cyc(3);
    rst = 1'b0;
    cyc(2);
    t_timed();
    t_remote_batt();
    t_remote_mains();
    t_invert();
    t_service();
    t_alarm();
    t_freeze();
    t_custom();
    t_pc_seq();
    t_pc();
    complete_run();
  end
  initial begin
    repeat (5000) @(posedge mclk);
    n_errors++;
    complete_run();
  end
endmodule : tb_backup_power_mode_sequencer
bind bpms_sequencer bpms_sequencer_checker u_chk (.mclk(mclk), .rst(rst), .ce(ce), .mains_ok_pin(mains_ok_pin),
  .remote_n_pin(remote_n_pin), .switch_pos(switch_pos), .storage_dv(storage_dv), .cfg(cfg), .stat(stat));
